// [hw/ngr_pkg.sv]
package ngr_pkg;
  // ********************************************************************
  // Address map
  // ********************************************************************
  localparam logic [15:0] PAGE_BASE_ADDR  = 16'hffff;
  localparam logic [7:0]  PAGE_BASE_RESET = 8'h00;
  localparam int          PAGE_BITS       = 8;
  localparam int          BUF_DEPTH       = 1024;
  localparam int          BUF_AW          = 10;
  localparam int          NREG            = 16;
  localparam logic [7:0]  REG_BUF_LO      = 8'h00;
  localparam logic [7:0]  REG_BUF_HI      = 8'h01;
  localparam logic [7:0]  REG_BUF_DATA    = 8'h02;
  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int          CLK_MHZ         = 200;
  localparam logic [7:0]  RATE_DIV_RESET  = 8'h28;

  // Interrupt destinations, one-hot
  typedef enum logic [2:0] {
    NGR_DEST_INT0 = 3'h1,
    NGR_DEST_INT1 = 3'h2,
    NGR_DEST_GPIO = 3'h4
  } ngr_dest_t;
  localparam ngr_dest_t DEST_RESET = NGR_DEST_INT0;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } ngr_xbus_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } ngr_port8_t;
endpackage : ngr_pkg

// [hw/ngr_glue.sv]
// Contract
// RULE1: Backplane mode drives clock at twice rate
// RULE2: Strap pin sampled at reset sets polarity
// RULE3: Transmit enable asserted while transmitting
// RULE4: Emulate select high floats core outputs
// RULE5: Board holds emulate select low normally
// RULE6: Low port muxed addr/data, high upper
// RULE7: Registers decoded into relocatable 256-byte page
// RULE8: Emulator reaches network registers in emulate
// RULE9: Interrupt routed to INT0, INT1 or GPIO
// RULE10: Routed interrupt wire-ORed with pin
// RULE11: Register access adds no wait states
// RULE12: Network core holds 1K buffer RAM
// RULE13: Page base register at FFFFh, reset 00h
// RULE14: Reset active high clears glue state; here RSTN_I is active low and clears it when held low
// RULE15: Emulate turns strobes to inputs, ints out
// RULE16: Interrupt destination resets to defined default
`timescale 1ns/1ps
`default_nettype none
module ngr_glue (
  input  wire logic              CORE_CLK_I,
  input  wire logic              RSTN_I,
  input  wire logic              EMULATE_SELECT_N_I,
  input  wire ngr_pkg::ngr_xbus_t CORE_BUS_I,
  input  wire logic              CORE_ALE_I,
  input  wire logic              CORE_PROGRAM_STORE_STROBE_N_I,
  input  wire logic [7:0]        LOW_ADDR_DATA_PORT_I,
  input  wire logic [7:0]        HIGH_ADDR_PORT_I,
  input  wire logic              EXT_RD_N_I,
  input  wire logic              EXT_WR_N_I,
  input  wire logic              EXT_ALE_I,
  input  wire logic              EXT_INT0_N_I,
  input  wire logic              EXT_INT1_N_I,
  input  wire ngr_pkg::ngr_dest_t INT_DEST_I,
  input  wire logic [2:0]        INT_GPIO_BIT_I,
  input  wire logic              NET_IRQ_I,
  input  wire logic              BACKPLANE_I,
  input  wire logic              TRANSMITTING_I,
  input  wire logic [7:0]        RATE_DIV_I,
  input  wire logic              BACKPLANE_CLOCK_OUT_I,
  output logic [7:0]             CORE_RDATA_O,
  output logic [7:0]             CORE_INT_N_O,
  output ngr_pkg::ngr_port8_t    LOW_ADDR_DATA_PORT_O,
  output ngr_pkg::ngr_port8_t    HIGH_ADDR_PORT_O,
  output logic [2:0]             STROBES_N_O,
  output logic [2:0]             STROBES_OE_O,
  output logic [1:0]             EXT_INT_N_O,
  output logic [1:0]             EXT_INT_OE_O,
  output logic                   GPIO_IRQ_N_O,
  output logic [7:0]             GPIO_IRQ_OE_O,
  output logic                   BACKPLANE_CLOCK_OUT_O,
  output logic                   BACKPLANE_CLOCK_OUT_OE_O,
  output logic                   TRANSMIT_DRIVER_ENABLE_O,
  output logic                   TX_POL_LOW_O,
  output logic [7:0]             PAGE_BASE_SELECT_O,
  output logic                   NET_SEL_O,
  output logic [7:0]             NET_ADDR_O,
  output logic [7:0]             NET_WDATA_O,
  output logic                   NET_WR_O,
  output logic                   NET_RD_O
);
  import ngr_pkg::*;

  // ********************************************************************
  // Access source: core or external emulator
  // ********************************************************************
  logic        emu;
  logic [7:0]  alat;
  logic        ale_q;
  logic        rd_n_q;
  logic        wr_n_q;
  logic [15:0] acc_addr;
  logic [7:0]  acc_wdata;
  logic        acc_rd;
  logic        acc_wr;

  // A level: high hands the bus to the emulator
  assign emu = EMULATE_SELECT_N_I;

  // Emulator cycles latch the low address at each clock while the address strobe is high
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      alat   <= 8'h00;
      ale_q  <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end else begin
      ale_q  <= EXT_ALE_I;
      rd_n_q <= EXT_RD_N_I;
      wr_n_q <= EXT_WR_N_I;
      if (EXT_ALE_I) begin
        alat <= LOW_ADDR_DATA_PORT_I; // RULE6
      end
    end
  end

  // One access per strobe edge; no wait state is ever inserted
  always_comb begin
    if (emu) begin // RULE8
      acc_addr  = {HIGH_ADDR_PORT_I, alat}; // RULE15
      acc_wdata = LOW_ADDR_DATA_PORT_I;
      acc_rd    = rd_n_q & ~EXT_RD_N_I;
      acc_wr    = ~wr_n_q & EXT_WR_N_I;
    end else begin
      acc_addr  = CORE_BUS_I.addr;
      acc_wdata = CORE_BUS_I.wdata;
      acc_rd    = CORE_BUS_I.rd;
      acc_wr    = CORE_BUS_I.wr;
    end
  end

  // ********************************************************************
  // Page decoder
  // ********************************************************************
  logic [7:0] page_base;
  logic       hit_base;
  logic       hit_page;

  // The base register sits outside the page, so it always stays reachable
  assign hit_base = (acc_addr == PAGE_BASE_ADDR);
  assign hit_page = (acc_addr[15:8] == page_base) && !hit_base; // RULE7

  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      page_base <= PAGE_BASE_RESET; // RULE13 RULE14
    end else if (acc_wr && hit_base) begin
      page_base <= acc_wdata; // RULE13
    end
  end

  // ********************************************************************
  // Packet buffer reached through pointer and data registers
  // ********************************************************************
  logic [7:0]        buf_mem [BUF_DEPTH];
  logic [BUF_AW-1:0] buf_ptr;
  logic [7:0]        rdata;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      buf_ptr <= '0;
    end else if (acc_wr && hit_page && acc_addr[7:0] == REG_BUF_LO) begin
      buf_ptr[7:0] <= acc_wdata;
    end else if (acc_wr && hit_page && acc_addr[7:0] == REG_BUF_HI) begin
      buf_ptr[BUF_AW-1:8] <= acc_wdata[1:0];
    end else if ((acc_wr || acc_rd) && hit_page && acc_addr[7:0] == REG_BUF_DATA) begin
      // Pointer wraps at the top of the buffer
      buf_ptr <= buf_ptr + 10'h001; // RULE12
    end
  end

  // Memory has no reset; contents are undefined until written
  always_ff @(posedge CORE_CLK_I) begin
    if (acc_wr && hit_page && acc_addr[7:0] == REG_BUF_DATA) begin
      buf_mem[buf_ptr] <= acc_wdata; // RULE12
    end
  end

  always_comb begin
    if (hit_base) begin
      rdata = page_base;
    end else if (acc_addr[7:0] == REG_BUF_LO) begin
      rdata = buf_ptr[7:0];
    end else if (acc_addr[7:0] == REG_BUF_HI) begin
      rdata = {6'h00, buf_ptr[9:8]};
    end else if (acc_addr[7:0] == REG_BUF_DATA) begin
      rdata = buf_mem[buf_ptr];
    end else begin
      rdata = 8'h00;
    end
  end

  // Read data registered in the same strobe cycle: no extra wait
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      CORE_RDATA_O <= 8'h00;
    end else if (acc_rd && (hit_page || hit_base)) begin
      CORE_RDATA_O <= rdata; // RULE11
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      NET_SEL_O   <= 1'b0;
      NET_ADDR_O  <= 8'h00;
      NET_WDATA_O <= 8'h00;
      NET_WR_O    <= 1'b0;
      NET_RD_O    <= 1'b0;
    end else begin
      // Registered so the network core sees clean one-cycle pulses
      NET_SEL_O   <= hit_page && (acc_rd || acc_wr);
      NET_ADDR_O  <= acc_addr[7:0];
      NET_WDATA_O <= acc_wdata;
      NET_WR_O    <= hit_page && acc_wr;
      NET_RD_O    <= hit_page && acc_rd;
    end
  end

  assign PAGE_BASE_SELECT_O = page_base;

  // ********************************************************************
  // Pin direction in emulate mode
  // ********************************************************************
  always_comb begin
    LOW_ADDR_DATA_PORT_O.out = (emu || CORE_ALE_I) ? CORE_BUS_I.addr[7:0] : CORE_BUS_I.wdata;
    LOW_ADDR_DATA_PORT_O.oe  = {8{~emu & (CORE_ALE_I | CORE_BUS_I.wr)}}; // RULE4 RULE6
    // Read data reaches the pins only while the emulator holds its strobe low
    if (emu && (hit_page || hit_base) && !EXT_RD_N_I) begin
      LOW_ADDR_DATA_PORT_O.out = CORE_RDATA_O;
      LOW_ADDR_DATA_PORT_O.oe  = 8'hff; // RULE8
    end
    HIGH_ADDR_PORT_O.out = CORE_BUS_I.addr[15:8]; // RULE6
    HIGH_ADDR_PORT_O.oe  = {8{~emu}}; // RULE4 RULE15
  end

  assign STROBES_N_O  = {~CORE_BUS_I.rd, ~CORE_BUS_I.wr, CORE_PROGRAM_STORE_STROBE_N_I};
  assign STROBES_OE_O = {3{~emu}}; // RULE4 RULE15

  // ********************************************************************
  // Interrupt router
  // ********************************************************************
  // Registered so a change of destination never glitches a pin
  ngr_dest_t dest;
  logic [2:0] gpio_bit;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      dest     <= DEST_RESET; // RULE16
      gpio_bit <= 3'h0;
    end else begin
      dest     <= INT_DEST_I; // RULE9
      gpio_bit <= INT_GPIO_BIT_I;
    end
  end

  logic irq0;
  logic irq1;
  logic irqg;

  assign irq0 = NET_IRQ_I && dest == NGR_DEST_INT0; // RULE9
  assign irq1 = NET_IRQ_I && dest == NGR_DEST_INT1;
  assign irqg = NET_IRQ_I && dest == NGR_DEST_GPIO;

  // Wired OR of active-low lines: either source pulls low
  always_comb begin
    CORE_INT_N_O    = 8'hff;
    CORE_INT_N_O[0] = EXT_INT0_N_I & ~irq0; // RULE10
    CORE_INT_N_O[1] = EXT_INT1_N_I & ~irq1; // RULE10
    CORE_INT_N_O[2] = ~irqg;
  end

  // In emulate mode the routed interrupt is shown to the emulator
  // Both lines are driven there, so the emulator always reads a level
  assign EXT_INT_N_O   = {~irq1, ~irq0};
  assign EXT_INT_OE_O  = {2{emu}}; // RULE15
  assign GPIO_IRQ_N_O  = 1'b0;
  assign GPIO_IRQ_OE_O = irqg ? (8'h01 << gpio_bit) : 8'h00; // RULE9

  // ********************************************************************
  // Backplane clock and transmit enable
  // ********************************************************************
  logic       strap_done;
  logic       pol_low;
  logic [7:0] div_cnt;
  logic       bp_clk;

  // Strap caught at the first clock after release, before the pin drives
  // Only a new reset samples the strap again
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      strap_done <= 1'b0;
      pol_low    <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      pol_low    <= ~BACKPLANE_CLOCK_OUT_I; // RULE2
    end
  end

  // Half period of RATE_DIV_I/4 cycles gives twice the data rate
  // A divisor under four is not supported: the count then wraps at 255
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I || !BACKPLANE_I || !strap_done) begin
      div_cnt <= 8'h00;
      bp_clk  <= 1'b0;
    end else if (div_cnt >= ((RATE_DIV_I >> 2) - 8'h01)) begin
      div_cnt <= 8'h00;
      bp_clk  <= ~bp_clk; // RULE1
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  assign BACKPLANE_CLOCK_OUT_O    = bp_clk;
  assign BACKPLANE_CLOCK_OUT_OE_O = BACKPLANE_I && strap_done; // RULE1
  assign TX_POL_LOW_O             = BACKPLANE_I && pol_low; // RULE2

  // Polarity folded in here so the pin comes straight from a flip-flop
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      TRANSMIT_DRIVER_ENABLE_O <= 1'b0;
    end else begin
      TRANSMIT_DRIVER_ENABLE_O <= TRANSMITTING_I ^ (BACKPLANE_I && pol_low); // RULE3
    end
  end
endmodule : ngr_glue
`default_nettype wire

// [verif/ngr_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ngr_core_model (
  input  wire logic            clk_i,
  output var ngr_pkg::ngr_xbus_t bus_o,
  output logic                 ale_o,
  output logic                 psen_n_o
);
  import ngr_pkg::*;
  initial begin
    bus_o = '0;
    ale_o = 1'b0;
    psen_n_o = 1'b1;
  end
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    ale_o = 1'b1;
    bus_o = '{addr: a, wdata: d, rd: ~w, wr: w};
    @(negedge clk_i);
    ale_o = 1'b0;
    // Released address and data show the inverse and rd and wr go low, so a stale value never passes
    bus_o = '{addr: ~a, wdata: ~d, rd: 1'b0, wr: 1'b0};
  endtask : xfer
endmodule : ngr_core_model
`default_nettype wire

// [verif/ngr_glue_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module ngr_glue_chk (
  input wire logic                CORE_CLK_I,
  input wire logic                RSTN_I,
  input wire logic                EMULATE_SELECT_N_I,
  input wire ngr_pkg::ngr_xbus_t  CORE_BUS_I,
  input wire logic                EXT_INT1_N_I,
  input wire ngr_pkg::ngr_dest_t  INT_DEST_I,
  input wire logic                NET_IRQ_I,
  input wire logic                BACKPLANE_I,
  input wire logic                TRANSMITTING_I,
  input wire logic [7:0]          CORE_INT_N_O,
  input wire ngr_pkg::ngr_port8_t HIGH_ADDR_PORT_O,
  input wire logic [2:0]          STROBES_OE_O,
  input wire logic                TRANSMIT_DRIVER_ENABLE_O,
  input wire logic                TX_POL_LOW_O,
  input wire logic [7:0]          PAGE_BASE_SELECT_O,
  input wire logic                NET_WR_O,
  input wire logic [7:0]          NET_ADDR_O
);
  import ngr_pkg::*;
  wire logic run = !EMULATE_SELECT_N_I;
  wire logic wr = run && CORE_BUS_I.wr;
  wire logic in_pg = CORE_BUS_I.addr[15:8] == PAGE_BASE_SELECT_O;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  a_page_reset: assert property ($rose(RSTN_I) |-> PAGE_BASE_SELECT_O == 8'h00)
    else $error("page base not cleared");
  a_page_write: assert property (wr && CORE_BUS_I.addr == 16'hffff
    |=> PAGE_BASE_SELECT_O == $past(CORE_BUS_I.wdata)) else $error("page base not written");
  a_net_hit: assert property (wr && in_pg && CORE_BUS_I.addr != 16'hffff
    |=> NET_WR_O && NET_ADDR_O == $past(CORE_BUS_I.addr[7:0])) else $error("page hit lost");
  a_net_miss: assert property (wr && !in_pg |=> !NET_WR_O)
    else $error("write outside page reached core");
  a_emul_float: assert property (EMULATE_SELECT_N_I
    |-> HIGH_ADDR_PORT_O.oe == 8'h00 && STROBES_OE_O == 3'h0) else $error("outputs driven");
  a_irq_route: assert property (run && NET_IRQ_I && $past(RSTN_I)
    && INT_DEST_I == NGR_DEST_INT1 && $past(INT_DEST_I) == NGR_DEST_INT1
    |-> !CORE_INT_N_O[1]) else $error("irq not routed");
  a_pin_or: assert property (run && !EXT_INT1_N_I |-> !CORE_INT_N_O[1])
    else $error("pin interrupt lost");
  a_tx_enable: assert property ($past(RSTN_I) && $past(RSTN_I, 2)
    |-> TRANSMIT_DRIVER_ENABLE_O == ($past(TRANSMITTING_I) ^ $past(TX_POL_LOW_O)))
    else $error("transmit enable wrong");
  a_pol_mode: assert property (!BACKPLANE_I |-> !TX_POL_LOW_O)
    else $error("polarity outside backplane");
  c_hit: cover property (NET_WR_O);
  c_emul: cover property (EMULATE_SELECT_N_I);
  c_low_pol: cover property (TX_POL_LOW_O && !TRANSMIT_DRIVER_ENABLE_O);
endmodule : ngr_glue_chk
bind ngr_glue ngr_glue_chk u_chk (.CORE_CLK_I, .RSTN_I, .EMULATE_SELECT_N_I, .CORE_BUS_I,
  .EXT_INT1_N_I, .INT_DEST_I, .NET_IRQ_I, .BACKPLANE_I, .TRANSMITTING_I, .CORE_INT_N_O,
  .HIGH_ADDR_PORT_O, .STROBES_OE_O, .TRANSMIT_DRIVER_ENABLE_O, .TX_POL_LOW_O,
  .PAGE_BASE_SELECT_O, .NET_WR_O, .NET_ADDR_O);
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ngr_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, emu = 1'b0, irq = 1'b0, bp = 1'b0, tx = 1'b0;
  logic strap = 1'b1, i0 = 1'b1, i1 = 1'b1, ale, psen, bco, bcoe, tde, pol, nwr;
  logic [7:0] rdiv = 8'h08, rdata, cint, pbs, naddr, nwd, gpoe;
  logic [2:0] gbit = 3'h5, soe;
  logic [1:0] eoe;
  ngr_dest_t dest = NGR_DEST_INT0;
  ngr_xbus_t bus;
  ngr_port8_t hap, ldp;
  logic [7:0] elad = 8'h00, ehad = 8'h00;
  logic erd_n = 1'b1, ewr_n = 1'b1, eale = 1'b0, nsel, nrd, gpn;
  logic [2:0] sn;
  logic [1:0] eint;
  int err_total = 0, comparisons = 0, cycles = 0;
  // Strap pin reads the strap only while the clock driver is off
  wire logic bpin = bcoe ? bco : strap;
  always #2.5 clk = ~clk;
  ngr_core_model u_core (.clk_i(clk), .bus_o(bus), .ale_o(ale), .psen_n_o(psen));
  ngr_glue u_dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .EMULATE_SELECT_N_I(emu),
    .CORE_BUS_I(bus), .CORE_ALE_I(ale), .CORE_PROGRAM_STORE_STROBE_N_I(psen),
    .LOW_ADDR_DATA_PORT_I(elad), .HIGH_ADDR_PORT_I(ehad), .EXT_RD_N_I(erd_n),
    .EXT_WR_N_I(ewr_n), .EXT_ALE_I(eale), .EXT_INT0_N_I(i0), .EXT_INT1_N_I(i1),
    .INT_DEST_I(dest), .INT_GPIO_BIT_I(gbit), .NET_IRQ_I(irq), .BACKPLANE_I(bp),
    .TRANSMITTING_I(tx), .RATE_DIV_I(rdiv), .BACKPLANE_CLOCK_OUT_I(bpin),
    .CORE_RDATA_O(rdata), .CORE_INT_N_O(cint), .LOW_ADDR_DATA_PORT_O(ldp),
    .HIGH_ADDR_PORT_O(hap), .STROBES_N_O(sn), .STROBES_OE_O(soe), .EXT_INT_N_O(eint),
    .EXT_INT_OE_O(eoe), .GPIO_IRQ_N_O(gpn), .GPIO_IRQ_OE_O(gpoe),
    .BACKPLANE_CLOCK_OUT_O(bco), .BACKPLANE_CLOCK_OUT_OE_O(bcoe),
    .TRANSMIT_DRIVER_ENABLE_O(tde), .TX_POL_LOW_O(pol), .PAGE_BASE_SELECT_O(pbs),
    .NET_SEL_O(nsel), .NET_ADDR_O(naddr), .NET_WDATA_O(nwd), .NET_WR_O(nwr), .NET_RD_O(nrd));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic do_reset();
    rstn = 1'b0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
  endtask : do_reset
  // Emulator cycle: address with the latch strobe, write lands at the rising strobe
  task automatic e_xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                        output logic [17:0] got);
    @(negedge clk);
    eale = 1'b1;
    ehad = a[15:8];
    elad = a[7:0];
    @(negedge clk);
    eale = 1'b0;
    elad = d;
    ewr_n = ~w;
    erd_n = w;
    @(negedge clk);
    got = {nsel, nrd, ldp.oe, ldp.out};
    ewr_n = 1'b1;
    erd_n = 1'b1;
    @(negedge clk);
  endtask : e_xfer
  task automatic t_page();
    chk(pbs, 8'h00);
    u_core.xfer(1'b1, 16'hffff, 8'h80);
    chk(pbs, 8'h80);
    u_core.xfer(1'b1, 16'h8005, 8'h3c);
    chk({nwr, naddr, nwd}, {1'b1, 8'h05, 8'h3c});
    u_core.xfer(1'b1, 16'h7f05, 8'h3c);
    chk(nwr, 1'b0);
  endtask : t_page
  task automatic t_buf();
    // Last location then wrap to zero, so the 10-bit pointer limit shows
    u_core.xfer(1'b1, 16'h8000, 8'hff);
    u_core.xfer(1'b1, 16'h8001, 8'h03);
    u_core.xfer(1'b1, 16'h8002, 8'haa);
    u_core.xfer(1'b1, 16'h8002, 8'hbb);
    u_core.xfer(1'b1, 16'h8000, 8'hff);
    u_core.xfer(1'b1, 16'h8001, 8'h03);
    u_core.xfer(1'b0, 16'h8002, 8'h00);
    chk(rdata, 8'haa);
    u_core.xfer(1'b0, 16'h8002, 8'h00);
    chk(rdata, 8'hbb);
  endtask : t_buf
  task automatic t_irq();
    irq = 1'b1;
    @(negedge clk);
    chk(cint[1:0], 2'b10);
    dest = NGR_DEST_INT1;
    repeat (2) @(negedge clk);
    chk(cint[1:0], 2'b01);
    dest = NGR_DEST_GPIO;
    repeat (2) @(negedge clk);
    chk({cint[2:0], gpn, gpoe}, {3'b011, 1'b0, 8'h20});
    irq = 1'b0;
    i1 = 1'b0;
    @(negedge clk);
    chk(cint[1:0], 2'b01);
    i1 = 1'b1;
  endtask : t_irq
  task automatic t_emu();
    logic [17:0] got;
    emu = 1'b1;
    @(negedge clk);
    chk({hap.oe, soe, eoe, eint}, {8'h00, 3'h0, 2'h3, 2'h3});
    e_xfer(1'b1, 16'hffff, 8'h40, got);
    chk(pbs, 8'h40);
    e_xfer(1'b1, 16'h4000, 8'h05, got);
    chk({nwr, naddr, nwd}, {1'b1, 8'h00, 8'h05});
    e_xfer(1'b0, 16'hffff, 8'h00, got);
    chk(got, {1'b0, 1'b0, 8'hff, 8'h40});
    e_xfer(1'b0, 16'h4000, 8'h00, got);
    chk(got, {1'b1, 1'b1, 8'hff, 8'h05});
    emu = 1'b0;
    @(negedge clk);
    chk({soe, eoe, sn, hap.oe, ldp.oe}, {3'h7, 2'h0, 3'h7, 8'hff, 8'h00});
  endtask : t_emu
  task automatic t_bp();
    int n = 0;
    logic prev;
    bp = 1'b1;
    repeat (4) @(negedge clk);
    prev = bco;
    // Half period of two cycles gives 32 edges in 64 cycles
    for (int i = 0; i < 64; i++) begin
      @(negedge clk);
      if (bco !== prev) n++;
      prev = bco;
    end
    chk({bcoe, n[7:0]}, {1'b1, 8'h20});
    tx = 1'b1;
    repeat (2) @(negedge clk);
    chk(tde, 1'b1);
    // Destination default shows while reset is held
    dest = NGR_DEST_GPIO;
    irq = 1'b1;
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    chk(cint[2:0], 3'b110);
    irq = 1'b0;
    dest = NGR_DEST_INT0;
    bp = 1'b0;
    strap = 1'b0;
    do_reset();
    bp = 1'b1;
    repeat (2) @(negedge clk);
    chk({pol, tde}, {1'b1, 1'b0});
    tx = 1'b0;
    repeat (2) @(negedge clk);
    chk(tde, 1'b1);
  endtask : t_bp
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    do_reset();
    t_page();
    t_buf();
    t_irq();
    t_emu();
    t_bp();
    summarize();
  end
endmodule : tb
`default_nettype wire
